// >>> hw/adcsop_regs.vh
// register map, field positions, reset values and timing counts
`ifndef ADCSOP_REGS_VH
`define ADCSOP_REGS_VH

// ==========================================================
// register offsets (byte addresses)
`define ADCSOP_CTRL_ADDR        8'h00
`define ADCSOP_STATUS_ADDR      8'h04
`define ADCSOP_RESULT_ADDR      8'h08

// ==========================================================
// control register fields (write one to start)
`define ADCSOP_CTRL_CAL_BIT     0
`define ADCSOP_CTRL_SYNC_BIT    1
`define ADCSOP_CTRL_RST_BIT     2

// ==========================================================
// status register fields
`define ADCSOP_STAT_VALID_BIT   0
`define ADCSOP_STAT_SKIP_BIT    1
`define ADCSOP_STAT_CLOCK_EDGE_SELECT_BIT    2
`define ADCSOP_STAT_FRAME_FORMAT_SELECT_BIT    3
`define ADCSOP_STAT_SKIP_LSB    8
`define ADCSOP_STAT_SKIP_MSB    14

// ==========================================================
// reset values
`define ADCSOP_RESULT_RESET     16'h0000
`define ADCSOP_BIT_RESET        5'h1f
`define ADCSOP_SKIP_RESET       7'h00

// ==========================================================
// timing counts, in master clock cycles, bit clock cycles or results
`define ADCSOP_VALID_HOLD       8192
`define ADCSOP_FRAME_LAST       5'h1f
`define ADCSOP_DATA_BITS        5'h10
`define ADCSOP_SKIP_RESULTS     7'h7f

`endif

// >>> hw/adcsop_sync.v
// two flip-flop synchroniser for a group of pin inputs
module adcsop_sync #(
   parameter WIDTH = 5
) (
   // clock and reset
   input  wire             clk_in,
   input  wire             resetn_in,
   // pins and synchronised copies
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] stable_q;

   // ======================================================
   // one pair of stages per pin
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clk_in) begin
            if (!resetn_in) begin
               meta_q[i]   <= 1'b0;
               stable_q[i] <= 1'b0;
            end else begin
               meta_q[i]   <= async_in[i];
               stable_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign sync_out = stable_q;

endmodule

// >>> hw/adcsop_hold.v
// result-valid hold-off timer
`include "adcsop_regs.vh"
module adcsop_hold #(
   parameter HOLD_CYCLES = `ADCSOP_VALID_HOLD
) (
   // clock and reset
   input  wire clk_in,
   input  wire resetn_in,
   // restart of the hold-off window
   input  wire load_in,
   // result valid level
   output reg  valid_out
);

   localparam [14:0] HOLD_LOAD = HOLD_CYCLES[14:0];

   reg [14:0] count_q;
   reg [14:0] count_d;

   // ======================================================
   // countdown; a new load restarts the whole window
   always @* begin
      count_d = count_q;
      if (load_in) begin
         count_d = HOLD_LOAD;
      end else if (count_q != 15'h0000) begin
         count_d = count_q - 15'h0001;
      end
   end

   // reset itself opens a full window: valid stays low after reset
   always @(posedge clk_in) begin
      if (!resetn_in) begin
         count_q   <= HOLD_LOAD;
         valid_out <= 1'b0;
      end else begin
         count_q   <= count_d;
         valid_out <= (count_d == 15'h0000);
      end
   end

endmodule

// >>> hw/adcsop_port.v
// serial output port of the converter, with wishbone control registers
//
// What this block does
// - valid high when accurate; low 8192 cycles
// - edge select low: falling, or rising
// - edge select high: rising, or falling
// - time slot level picks active enable
// - drive data only when enable equals slot
// - format low: one-bit pulse every 32
// - format high: sync low over 16 bits
// - sync input rise restarts the frame
// - next 127 results flagged, valid stays
// - aligned sync edges leave frame untouched
// - steady sync input means free running
// - bit clock is half master clock
// - frame lasts 32 bit clocks
// - msb first, then sixteen zeros
// - frame sync marks each word start
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`include "adcsop_regs.vh"
module adcsop_port #(
   parameter VALID_HOLD_CYCLES = `ADCSOP_VALID_HOLD
) (
   // clock and reset
   input  wire        CLOCK_IN,
   input  wire        RESETN_IN,
   // wishbone slave
   input  wire        WB_CYC_IN,
   input  wire        WB_STB_IN,
   input  wire        WB_WE_IN,
   input  wire [7:0]  WB_ADR_IN,
   input  wire [3:0]  WB_SEL_IN,
   input  wire [31:0] WB_DAT_IN,
   output reg  [31:0] WB_DAT_OUT,
   output wire        WB_ACK_OUT,
   // conversion results from the filter
   input  wire [15:0] RESULT_IN,
   input  wire        RESULT_STROBE_IN,
   input  wire        OVERRANGE_IN,
   // configuration and sync pins
   input  wire        CLOCK_EDGE_SELECT_IN,
   input  wire        FRAME_FORMAT_SELECT_IN,
   input  wire        TIME_SLOT_LEVEL_IN,
   input  wire        SERIAL_OUT_ENABLE_IN,
   input  wire        FRAME_SYNC_IN,
   // serial link
   output reg         BIT_CLOCK_OUT,
   output reg         FRAME_SYNC_OUT,
   output reg         SERIAL_DATA_OUT,
   output reg         SERIAL_DATA_OE_OUT,
   output wire        RESULT_VALID_OUT
);

   // =======================================================
   // pin synchronisation
   wire [4:0] pins_s;
   wire       clock_edge_select_s;
   wire       frame_format_select_s;
   wire       tsi_s;
   wire       oe_s;
   wire       fsi_s;

   adcsop_sync #(
      .WIDTH     (5)
   ) u_sync (
      .clk_in    (CLOCK_IN),
      .resetn_in (RESETN_IN),
      .async_in  ({FRAME_SYNC_IN, SERIAL_OUT_ENABLE_IN,
                   TIME_SLOT_LEVEL_IN, FRAME_FORMAT_SELECT_IN,
                   CLOCK_EDGE_SELECT_IN}),
      .sync_out  (pins_s)
   );

   assign clock_edge_select_s = pins_s[0];
   assign frame_format_select_s = pins_s[1];
   assign tsi_s  = pins_s[2];
   assign oe_s   = pins_s[3];
   assign fsi_s  = pins_s[4];

   // =======================================================
   // wishbone decode
   reg         ack_q;
   reg         cal_cmd;
   reg         sync_cmd;
   reg         rst_cmd;
   wire        wb_req;
   wire        wb_wr;
   wire [5:0]  wb_word;

   assign wb_req     = WB_CYC_IN & WB_STB_IN & ~ack_q;
   assign wb_wr      = wb_req & WB_WE_IN;
   assign wb_word    = WB_ADR_IN[7:2];
   assign WB_ACK_OUT = ack_q;

   function is_reg;
      input [5:0] word;
      input [7:0] addr;
      begin
         is_reg = (word == addr[7:2]);
      end
   endfunction

   // command strobes are one-cycle pulses, taken on the request cycle
   always @* begin
      cal_cmd  = 1'b0;
      sync_cmd = 1'b0;
      rst_cmd  = 1'b0;
      if (wb_wr && WB_SEL_IN[0] &&
          is_reg(wb_word, `ADCSOP_CTRL_ADDR)) begin
         cal_cmd  = WB_DAT_IN[`ADCSOP_CTRL_CAL_BIT];
         sync_cmd = WB_DAT_IN[`ADCSOP_CTRL_SYNC_BIT];
         rst_cmd  = WB_DAT_IN[`ADCSOP_CTRL_RST_BIT];
      end
   end

   // =======================================================
   // result holding register
   reg [15:0] result_q;

   always @(posedge CLOCK_IN) begin
      if (!RESETN_IN || rst_cmd) begin
         result_q <= `ADCSOP_RESULT_RESET;
      end else if (RESULT_STROBE_IN) begin
         result_q <= RESULT_IN;
      end
   end

   // =======================================================
   // result valid hold-off
   wire hold_load;

   // overrange and each started cal, sync or reset drop valid
   assign hold_load = OVERRANGE_IN | cal_cmd | sync_cmd | rst_cmd;

   adcsop_hold #(
      .HOLD_CYCLES (VALID_HOLD_CYCLES)
   ) u_hold (
      .clk_in      (CLOCK_IN),
      .resetn_in   (RESETN_IN),
      .load_in     (hold_load),
      .valid_out   (RESULT_VALID_OUT)
   );

   // =======================================================
   // frame sync input edge
   reg  fsi_prev_q;
   wire fsi_rise;

   // a steady level never produces a rise, so frames just free-run
   assign fsi_rise = fsi_s & ~fsi_prev_q;

   always @(posedge CLOCK_IN) begin
      if (!RESETN_IN) begin
         fsi_prev_q <= 1'b0;
      end else begin
         fsi_prev_q <= fsi_s;
      end
   end

   // =======================================================
   // frame timing
   reg        phase_q;
   reg        phase_d;
   reg [4:0]  bit_q;
   reg [4:0]  bit_d;
   reg [15:0] shift_q;
   reg [15:0] shift_d;
   reg        clock_edge_select_q;
   reg        clock_edge_select_d;
   reg        frame_format_select_q;
   reg        frame_format_select_d;
   wire       frame_end;
   wire       ext_restart;
   wire       restart;
   wire       start;
   wire       data_fall_valid;

   // last master cycle of the last bit of the frame
   assign frame_end = phase_q & (bit_q == `ADCSOP_FRAME_LAST);

   // a rise landing on the natural frame start changes nothing
   assign ext_restart = fsi_rise & ~frame_end;
   assign restart     = ext_restart | sync_cmd | rst_cmd;
   assign start       = frame_end | restart;

   always @* begin
      phase_d = ~phase_q;
      bit_d   = bit_q;
      shift_d = shift_q;
      clock_edge_select_d  = clock_edge_select_q;
      frame_format_select_d  = frame_format_select_q;
      if (start) begin
         // reload and restart the bit clock at a word boundary
         phase_d = 1'b0;
         bit_d   = 5'h00;
         shift_d = result_q;
         clock_edge_select_d  = clock_edge_select_s;
         frame_format_select_d  = frame_format_select_s;
      end else if (phase_q) begin
         bit_d   = bit_q + 5'h01;
         // zeros shift in behind the lsb for the back half
         shift_d = {shift_q[14:0], 1'b0};
      end
   end

   // data changes at each bit start; the clock is turned so that
   // the chosen edge falls in the middle of the bit
   assign data_fall_valid = ~(clock_edge_select_d ^ frame_format_select_d);

   always @(posedge CLOCK_IN) begin
      if (!RESETN_IN) begin
         phase_q <= 1'b1;
         bit_q   <= `ADCSOP_BIT_RESET;
         shift_q <= `ADCSOP_RESULT_RESET;
         clock_edge_select_q  <= 1'b0;
         frame_format_select_q  <= 1'b0;
      end else begin
         phase_q <= phase_d;
         bit_q   <= bit_d;
         shift_q <= shift_d;
         clock_edge_select_q  <= clock_edge_select_d;
         frame_format_select_q  <= frame_format_select_d;
      end
   end

   // =======================================================
   // link outputs, all from flip-flops
   always @(posedge CLOCK_IN) begin
      if (!RESETN_IN) begin
         BIT_CLOCK_OUT      <= 1'b0;
         FRAME_SYNC_OUT     <= 1'b0;
         SERIAL_DATA_OUT    <= 1'b0;
         SERIAL_DATA_OE_OUT <= 1'b0;
      end else begin
         BIT_CLOCK_OUT   <= phase_d ^ data_fall_valid;
         SERIAL_DATA_OUT <= shift_d[15];
         if (frame_format_select_d) begin
            // low across the sixteen data bits
            FRAME_SYNC_OUT <= ~(bit_d < `ADCSOP_DATA_BITS);
         end else begin
            // high for the whole first bit of each frame
            FRAME_SYNC_OUT <= (bit_d == 5'h00);
         end
         // enable is active at whichever level the slot pin holds;
         // tying both low (single converter) keeps the pin driven
         SERIAL_DATA_OE_OUT <= (oe_s == tsi_s);
      end
   end

   // =======================================================
   // invalid-result window after an external sync
   reg [6:0] skip_q;

   // valid pin is untouched here; only the count is reported
   always @(posedge CLOCK_IN) begin
      if (!RESETN_IN || rst_cmd) begin
         skip_q <= `ADCSOP_SKIP_RESET;
      end else if (ext_restart) begin
         skip_q <= `ADCSOP_SKIP_RESULTS;
      end else if (RESULT_STROBE_IN && skip_q != 7'h00) begin
         skip_q <= skip_q - 7'h01;
      end
   end

   // =======================================================
   // wishbone answer: ack one cycle after the request is seen
   reg [31:0] rdata;

   always @* begin
      rdata = 32'h0000_0000;
      if (is_reg(wb_word, `ADCSOP_STATUS_ADDR)) begin
         rdata[`ADCSOP_STAT_VALID_BIT] = RESULT_VALID_OUT;
         rdata[`ADCSOP_STAT_SKIP_BIT]  = (skip_q != 7'h00);
         rdata[`ADCSOP_STAT_CLOCK_EDGE_SELECT_BIT]  = clock_edge_select_q;
         rdata[`ADCSOP_STAT_FRAME_FORMAT_SELECT_BIT]  = frame_format_select_q;
         rdata[`ADCSOP_STAT_SKIP_MSB:`ADCSOP_STAT_SKIP_LSB] = skip_q;
      end else if (is_reg(wb_word, `ADCSOP_RESULT_ADDR)) begin
         rdata[15:0] = result_q;
      end
   end

   // unmapped offsets and the control word read as zero
   always @(posedge CLOCK_IN) begin
      if (!RESETN_IN) begin
         ack_q      <= 1'b0;
         WB_DAT_OUT <= 32'h0000_0000;
      end else begin
         ack_q <= wb_req;
         if (wb_req && !WB_WE_IN) begin
            WB_DAT_OUT <= rdata;
         end
      end
   end

endmodule

// >>> testbench/adcsop_port_properties.sv
// checker for the serial output port pins
module adcsop_port_props #(
   parameter VALID_HOLD_CYCLES = 16
) (
   // clock and reset
   input wire CLOCK_IN,
   input wire RESETN_IN,
   // bus and result side
   input wire WB_CYC_IN,
   input wire WB_WE_IN,
   input wire OVERRANGE_IN,
   // configuration and sync pins
   input wire CLOCK_EDGE_SELECT_IN,
   input wire FRAME_FORMAT_SELECT_IN,
   input wire TIME_SLOT_LEVEL_IN,
   input wire SERIAL_OUT_ENABLE_IN,
   input wire FRAME_SYNC_IN,
   // serial link
   input wire BIT_CLOCK_OUT,
   input wire FRAME_SYNC_OUT,
   input wire SERIAL_DATA_OUT,
   input wire SERIAL_DATA_OE_OUT,
   input wire RESULT_VALID_OUT
);
   timeunit 1ns;
   timeprecision 100ps;
   // ====================
   // quiet time since the last edge select, format, sync pin or bus write
   // frame checks skip restarts, where a frame may be cut short
   logic [6:0] calm_q;
   logic [2:0] pins_q;
   wire        fmt    = FRAME_FORMAT_SELECT_IN;
   wire        frame_sync_out    = FRAME_SYNC_OUT;
   wire [2:0]  pins_d = {CLOCK_EDGE_SELECT_IN, fmt, FRAME_SYNC_IN};
   wire        calm   = calm_q > 7'h64;
   always @(posedge CLOCK_IN) begin
      pins_q <= pins_d;
      if (!RESETN_IN || pins_q != pins_d || (WB_CYC_IN && WB_WE_IN))
         calm_q <= 7'h00;
      else if (calm_q != 7'h7f)
         calm_q <= calm_q + 7'h01;
   end
   default clocking dc @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RESETN_IN);
   // ====================
   // assertions
   a_bit_clock_rate: assert property (
      $stable(BIT_CLOCK_OUT) |=> $changed(BIT_CLOCK_OUT))
      else $error("bit clock held over two cycles");
   a_enable_match: assert property (
      (SERIAL_OUT_ENABLE_IN == TIME_SLOT_LEVEL_IN)[*4] |-> SERIAL_DATA_OE_OUT)
      else $error("data pin not driven in its slot");
   a_valid_hold: assert property (
      OVERRANGE_IN |-> ##2 !RESULT_VALID_OUT [*8])
      else $error("valid high during hold-off");
   a_frame_period: assert property (
      calm && $rose(frame_sync_out) |-> ##64 (!calm || $rose(frame_sync_out)))
      else $error("frame not 64 master cycles");
   a_pulse_width: assert property (
      calm && !fmt && $rose(frame_sync_out) |=> frame_sync_out ##1 (!calm || !frame_sync_out) [*8])
      else $error("sync pulse not one bit clock wide");
   a_frame_low: assert property (
      calm && fmt && $fell(frame_sync_out) |-> ##31 (!calm || !frame_sync_out) ##1 (!calm || frame_sync_out))
      else $error("frame sync not low over the word");
   a_trailing_zero: assert property (
      calm && fmt && frame_sync_out && $past(frame_sync_out) |-> !SERIAL_DATA_OUT)
      else $error("data not zero after the word");
   a_clock_phase: assert property (
      calm && $rose(frame_sync_out) |-> BIT_CLOCK_OUT == (CLOCK_EDGE_SELECT_IN == fmt))
      else $error("bit clock phase wrong for format");
   c_pulse_frame: cover property (calm && !fmt && $rose(frame_sync_out));
   c_long_frame: cover property (calm && fmt && $fell(frame_sync_out));
   c_overrange: cover property (OVERRANGE_IN ##2 !RESULT_VALID_OUT);
endmodule

bind adcsop_port adcsop_port_props #(
   .VALID_HOLD_CYCLES(VALID_HOLD_CYCLES)
) i_adcsop_port_props (
   .CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN),
   .WB_CYC_IN(WB_CYC_IN), .WB_WE_IN(WB_WE_IN),
   .OVERRANGE_IN(OVERRANGE_IN),
   .CLOCK_EDGE_SELECT_IN(CLOCK_EDGE_SELECT_IN),
   .FRAME_FORMAT_SELECT_IN(FRAME_FORMAT_SELECT_IN),
   .TIME_SLOT_LEVEL_IN(TIME_SLOT_LEVEL_IN),
   .SERIAL_OUT_ENABLE_IN(SERIAL_OUT_ENABLE_IN),
   .FRAME_SYNC_IN(FRAME_SYNC_IN), .BIT_CLOCK_OUT(BIT_CLOCK_OUT),
   .FRAME_SYNC_OUT(FRAME_SYNC_OUT), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
   .SERIAL_DATA_OE_OUT(SERIAL_DATA_OE_OUT),
   .RESULT_VALID_OUT(RESULT_VALID_OUT)
);

// >>> testbench/adcsop_dsp_rx.sv
// processor serial port model that collects result words
module adcsop_dsp_rx (
   // serial link from the converter
   input  wire         bclk_in,
   input  wire         fsync_in,
   input  wire         sdata_in,
   // format pins as wired on the board
   input  wire         edge_in,
   input  wire         fmt_in,
   // received words
   output logic [15:0] word_out,
   output logic [7:0]  words_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ====================
   // receiver
   logic [15:0] sr   = 16'h0000;
   logic [4:0]  n    = 5'h10;
   logic        fs_q = 1'b1;
   initial word_out = 16'h0000;
   initial words_out = 8'h00;
   // sample mid-bit, on the edge that the formats name as valid
   always @(bclk_in) begin
      if (bclk_in == (edge_in != fmt_in)) begin
         // word start: short pulse high, or long frame pulse just fell
         if (fmt_in ? (fs_q && !fsync_in) : fsync_in)
            n = 5'h00;
         if (n < 5'h10) begin
            sr = {sr[14:0], sdata_in};
            n = n + 5'h01;
            if (n == 5'h10) begin
               word_out = sr;
               words_out = words_out + 8'h01;
            end
         end
         fs_q = fsync_in;
      end
   end
endmodule

// >>> testbench/tb.sv
// top-level bench for the serial output port
`include "adcsop_regs.vh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HOLD = 16;
   logic        clk = 1'b0, rstn = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, strb = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hf;
   logic [31:0] wdat = 32'h0000_0000, got;
   logic [15:0] res = 16'h0000;
   logic        ovr = 1'b0, clock_edge_select = 1'b0, frame_format_select = 1'b0, frame_sync_in = 1'b0;
   logic        time_slot_level = 1'b0, serial_out_enable = 1'b0;
   logic        alt = 1'b0;
   logic [15:0] pat [4] = '{16'ha5c3, 16'h8002, 16'h1234, 16'hf00d};
   wire  [31:0] rdat;
   wire  [15:0] word;
   wire  [7:0]  words;
   wire         ack, bclk, frame_sync_out, serial_data_out, oe, result_valid;
   // a released line shows a moving pattern, not the last bit
   wire         line = oe ? serial_data_out : alt;
   int          err_total = 0, checks_done = 0;
   always #2 clk = ~clk;
   always @(posedge clk) alt <= ~alt;
   adcsop_port #(
      .VALID_HOLD_CYCLES(HOLD)
   ) i_adcsop_port (
      .CLOCK_IN(clk), .RESETN_IN(rstn),
      .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
      .RESULT_IN(res), .RESULT_STROBE_IN(strb), .OVERRANGE_IN(ovr),
      .CLOCK_EDGE_SELECT_IN(clock_edge_select), .FRAME_FORMAT_SELECT_IN(frame_format_select),
      .TIME_SLOT_LEVEL_IN(time_slot_level), .SERIAL_OUT_ENABLE_IN(serial_out_enable),
      .FRAME_SYNC_IN(frame_sync_in), .BIT_CLOCK_OUT(bclk),
      .FRAME_SYNC_OUT(frame_sync_out), .SERIAL_DATA_OUT(serial_data_out),
      .SERIAL_DATA_OE_OUT(oe), .RESULT_VALID_OUT(result_valid)
   );
   adcsop_dsp_rx i_adcsop_dsp_rx (
      .bclk_in(bclk), .fsync_in(frame_sync_out), .sdata_in(line),
      .edge_in(clock_edge_select), .fmt_in(frame_format_select), .word_out(word), .words_out(words)
   );
   // ====================
   // tasks
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] seen);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int t;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 50);
      got = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
      check("bus ack", 1'b1, t < 50);
   endtask
   task automatic strobe(input logic [15:0] v);
      res <= v;
      strb <= 1'b1;
      @(posedge clk);
      strb <= 1'b0;
   endtask
   task automatic frames(input int n);
      int t;
      logic [7:0] w0;
      t = 0;
      w0 = words;
      while (words - w0 != 8'(n) && t < 1000) begin
         @(posedge clk);
         t++;
      end
      check("word count", 1'b1, t < 1000);
   endtask
   task automatic valid_gap(output int t);
      t = 0;
      while (result_valid !== 1'b1 && t < 200) begin
         @(posedge clk);
         t++;
      end
   endtask
   task automatic fso_rise(output int t);
      logic p;
      t = 0;
      do begin
         p = frame_sync_out;
         @(posedge clk);
         t++;
      end while ((p !== 1'b0 || frame_sync_out !== 1'b1) && t < 200);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ====================
   // tests
   initial begin
      int t;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      valid_gap(t);
      check("valid at start", 1'b1, t >= HOLD && t <= HOLD + 4);
      for (int m = 0; m < 4; m++) begin
         {clock_edge_select, frame_format_select} <= 2'(m);
         strobe(pat[m]);
         frames(3);
         check("word", pat[m], word);
         wb(1'b0, `ADCSOP_STATUS_ADDR, 32'h0000_0000);
         check("formats", {frame_format_select, clock_edge_select}, got[3:2]);
         wb(1'b0, `ADCSOP_RESULT_ADDR, 32'h0000_0000);
         check("result", pat[m], got[15:0]);
      end
      for (int m = 0; m < 4; m++) begin
         {time_slot_level, serial_out_enable} <= 2'(m);
         repeat (6) @(posedge clk);
         check("data enable", m[1] == m[0], oe);
      end
      // enable tied to frame sync: each slot level drives half of a frame
      for (int s = 0; s < 2; s++) begin
         int hi;
         hi = 0;
         time_slot_level <= s[0];
         for (int c = 0; c < 136; c++) begin
            serial_out_enable <= frame_sync_out;
            @(posedge clk);
            if (c >= 8) hi += oe;
         end
         check("shared enable", 32'd64, hi);
      end
      {time_slot_level, serial_out_enable} <= 2'b00;
      ovr <= 1'b1;
      @(posedge clk);
      ovr <= 1'b0;
      repeat (2) @(posedge clk);
      check("valid in hold-off", 1'b0, result_valid);
      valid_gap(t);
      check("hold-off", 1'b1, t >= HOLD - 4 && t <= HOLD + 2);
      for (int b = 0; b < 3; b++) begin
         wb(1'b1, `ADCSOP_CTRL_ADDR, 32'h0000_0001 << b);
         check("valid after command", 1'b0, result_valid);
         valid_gap(t);
         check("valid back", 1'b1, t < HOLD + 4);
      end
      wb(1'b0, `ADCSOP_RESULT_ADDR, 32'h0000_0000);
      check("result cleared", `ADCSOP_RESULT_RESET, got[15:0]);
      wb(1'b0, 8'h3c, 32'h0000_0000);
      check("unmapped read", 32'h0000_0000, got);
      {clock_edge_select, frame_format_select} <= 2'b00;
      frames(2);
      fso_rise(t);
      repeat (20) @(posedge clk);
      frame_sync_in <= 1'b1;
      fso_rise(t);
      check("restart delay", 1'b1, t <= 8);
      check("valid kept", 1'b1, result_valid);
      wb(1'b0, `ADCSOP_STATUS_ADDR, 32'h0000_0000);
      check("skip count", `ADCSOP_SKIP_RESULTS, got[14:8]);
      strobe(16'h5a96);
      wb(1'b0, `ADCSOP_STATUS_ADDR, 32'h0000_0000);
      check("skip count", 7'h7e, got[14:8]);
      frames(2);
      check("word after restart", 16'h5a96, word);
      test_done();
   end
   initial begin
      #50us;
      err_total++;
      test_done();
   end
endmodule
